// ==== cpsm_map.svh ====
// Constants for the processor power state and management interrupt control
`ifndef CPSM_MAP_SVH
`define CPSM_MAP_SVH
`define CPSM_SYNC_STAGES 2
`define CPSM_ACK_CYCLES 4
`define CPSM_ACK_WIDTH 3
`define CPSM_BCLK_LOSS_CYCLES 64
`define CPSM_BCLK_CNT_WIDTH 7
`define CPSM_GATE_WIDTH 4
`define CPSM_GATE_BUS 0
`define CPSM_GATE_LIC 1
`define CPSM_GATE_CORE 2
`define CPSM_GATE_PLL 3
`define CPSM_GATE_ALL 4'hf
`define CPSM_GATE_STOPGRANT 4'hb
`define CPSM_GATE_SLEEP 4'h8
`define CPSM_GATE_DEEP 4'h0
`define CPSM_ACK_NONE 2'h0
`define CPSM_ACK_STOPGRANT 2'h1
`define CPSM_ACK_MGMT 2'h2
`endif

// ==== cpsm_pkg.sv ====
// Types for the processor power state and management interrupt control
`default_nettype none
package cpsm_pkg;
    typedef enum logic [2:0] {
        CPSM_RUN = 3'h0,
        CPSM_STOPGRANT = 3'h1,
        CPSM_SLEEP = 3'h2,
        CPSM_DEEP_SLEEP = 3'h3,
        CPSM_MGMT_SAVE = 3'h4,
        CPSM_MGMT_ACK = 3'h5,
        CPSM_MGMT_MODE = 3'h6
    } cpsm_state_t;
endpackage
`default_nettype wire

// ==== cpsm_ctrl.sv ====
// Power state sequencer and management interrupt entry control
//
// Operation
// (RQ1) Sleep asserted while in Stop-Grant moves the block into Sleep.
// (RQ2) Sleep gates every unit clock and leaves only the loop clock running.
// (RQ3) Sleep ignores bus snoops and interrupts completely.
// (RQ4) Sleep reacts only to reset, sleep release, deep sleep and clock loss.
// (RQ5) Sleep release returns to Stop-Grant with bus and interrupt unit clocks back on.
// (RQ6) Deep sleep asserted in Sleep moves the block into Deep Sleep.
// (RQ7) Stop-clock entry goes to Stop-Grant and issues its acknowledge.
// (RQ8) Stop-Grant gates all core clocks except bus and interrupt units.
// (RQ9) Stop-Grant keeps snooping the bus and servicing interrupts.
// (RQ10) Stop-clock release restarts all clocks and resumes execution.
// (RQ11) Stop-clock is asynchronous and never touches the bus clock.
// (RQ12) Management interrupt is accepted at any timing relative to the clock.
// (RQ13) An accepted management interrupt saves state and enters that mode.
// (RQ14) The mode then issues its acknowledge before the handler starts.
// (RQ15) Management interrupt held as reset lifts tristates the outputs.
// (RQ16) Every asynchronous request passes a clocked multi-stage synchroniser.
`default_nettype none
`include "cpsm_map.svh"
module cpsm_ctrl #(
    parameter int SYNC_STAGES = `CPSM_SYNC_STAGES,
    parameter int ACK_CYCLES = `CPSM_ACK_CYCLES,
    parameter int BCLK_LOSS_CYCLES = `CPSM_BCLK_LOSS_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic stop_clock_request_n,
    input wire logic sleep_request_n,
    input wire logic deep_sleep_request_n,
    input wire logic mgmt_interrupt_n,
    input wire logic bus_clock_present,
    input wire logic snoop_request,
    input wire logic interrupt_request,
    input wire logic mgmt_handler_done,
    output logic [`CPSM_GATE_WIDTH-1:0] unit_clock_enable,
    output logic ack_valid,
    output logic [1:0] ack_kind,
    output logic snoop_accept,
    output logic interrupt_accept,
    output logic state_save,
    output logic handler_start,
    output logic executing,
    output logic system_management_mode,
    output logic outputs_tristate,
    output logic [2:0] power_state
);
    if (SYNC_STAGES < 2 || ACK_CYCLES < 1 || ACK_CYCLES > 7 ||
        BCLK_LOSS_CYCLES < 1 || BCLK_LOSS_CYCLES > 127) begin : g_bad_param
        $error("cpsm_ctrl: unsupported parameter value");
    end

    // Synchroniser chains, bit 0 is the first stage
    logic [SYNC_STAGES-1:0] stop_clock_request_n_sync;
    logic [SYNC_STAGES-1:0] slp_sync;
    logic [SYNC_STAGES-1:0] deep_sleep_request_n_sync;
    logic [SYNC_STAGES-1:0] mgmt_sync;
    logic [SYNC_STAGES-1:0] bclk_sync;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stop_clock_request_n_sync <= '0;
            slp_sync <= '0;
            deep_sleep_request_n_sync <= '0;
            mgmt_sync <= '0;
            bclk_sync <= {SYNC_STAGES{1'b1}};
        end else begin
            // Active-high request levels after inversion [RQ11] [RQ12] [RQ16]
            stop_clock_request_n_sync <= {stop_clock_request_n_sync[SYNC_STAGES-2:0],
                            ~stop_clock_request_n};
            slp_sync <= {slp_sync[SYNC_STAGES-2:0], ~sleep_request_n};
            deep_sleep_request_n_sync <= {deep_sleep_request_n_sync[SYNC_STAGES-2:0],
                           ~deep_sleep_request_n};
            mgmt_sync <= {mgmt_sync[SYNC_STAGES-2:0], ~mgmt_interrupt_n};
            bclk_sync <= {bclk_sync[SYNC_STAGES-2:0], bus_clock_present};
        end
    end

    logic stop_clock_request_n_req;
    logic slp_req;
    logic deep_sleep_request_n_req;
    logic mgmt_req;
    logic bclk_ok;
    assign stop_clock_request_n_req = stop_clock_request_n_sync[SYNC_STAGES-1];
    assign slp_req = slp_sync[SYNC_STAGES-1];
    assign deep_sleep_request_n_req = deep_sleep_request_n_sync[SYNC_STAGES-1];
    assign mgmt_req = mgmt_sync[SYNC_STAGES-1];
    assign bclk_ok = bclk_sync[SYNC_STAGES-1];

    // Strap taken from the synchronised pin, sampled once strap_wait fills,
    // SYNC_STAGES+1 edges after release; the raw pin is never read here
    logic [SYNC_STAGES-1:0] strap_wait;
    logic strap_taken;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            strap_wait <= '0;
            strap_taken <= 1'b0;
            outputs_tristate <= 1'b0;
        end else begin
            strap_wait <= {strap_wait[SYNC_STAGES-2:0], 1'b1};
            if (strap_wait[SYNC_STAGES-1] && !strap_taken) begin
                strap_taken <= 1'b1;
                outputs_tristate <= mgmt_req; // [RQ15]
            end
        end
    end

    // Management interrupt edge latch so a short pulse is not lost
    logic mgmt_prev;
    logic mgmt_pending;
    logic mgmt_taken;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mgmt_prev <= 1'b0;
        end else begin
            mgmt_prev <= mgmt_req;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mgmt_pending <= 1'b0;
        end else if (mgmt_req && !mgmt_prev) begin
            mgmt_pending <= 1'b1; // Set wins over clear [RQ12]
        end else if (mgmt_taken) begin
            mgmt_pending <= 1'b0;
        end
    end

    // Bus clock loss watchdog
    logic [`CPSM_BCLK_CNT_WIDTH-1:0] bclk_cnt;
    logic bclk_lost;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bclk_cnt <= '0;
        end else if (bclk_ok) begin
            bclk_cnt <= '0;
        end else if (!bclk_lost) begin
            bclk_cnt <= bclk_cnt + 1'b1;
        end
    end
    assign bclk_lost =
        (bclk_cnt == BCLK_LOSS_CYCLES[`CPSM_BCLK_CNT_WIDTH-1:0]);

    cpsm_pkg::cpsm_state_t state;
    cpsm_pkg::cpsm_state_t next_state;
    logic [`CPSM_ACK_WIDTH-1:0] ack_cnt;
    logic ack_done;
    assign ack_done = (ack_cnt == '0);

    always_comb begin
        next_state = state;
        mgmt_taken = 1'b0;
        unique case (state)
            cpsm_pkg::CPSM_RUN: begin
                if (mgmt_pending) begin
                    next_state = cpsm_pkg::CPSM_MGMT_SAVE; // [RQ13]
                    mgmt_taken = 1'b1;
                end else if (stop_clock_request_n_req) begin
                    next_state = cpsm_pkg::CPSM_STOPGRANT; // [RQ7]
                end
            end
            cpsm_pkg::CPSM_STOPGRANT: begin
                if (!stop_clock_request_n_req) begin
                    next_state = cpsm_pkg::CPSM_RUN; // [RQ10]
                end else if (slp_req) begin
                    next_state = cpsm_pkg::CPSM_SLEEP; // [RQ1]
                end
            end
            cpsm_pkg::CPSM_SLEEP: begin
                // Only these events are seen here [RQ4]
                if (deep_sleep_request_n_req || bclk_lost) begin
                    next_state = cpsm_pkg::CPSM_DEEP_SLEEP; // [RQ6]
                end else if (!slp_req) begin
                    next_state = cpsm_pkg::CPSM_STOPGRANT; // [RQ5]
                end
            end
            cpsm_pkg::CPSM_DEEP_SLEEP: begin
                if (!deep_sleep_request_n_req && bclk_ok) begin
                    next_state = cpsm_pkg::CPSM_SLEEP;
                end
            end
            cpsm_pkg::CPSM_MGMT_SAVE: begin
                next_state = cpsm_pkg::CPSM_MGMT_ACK; // [RQ14]
            end
            cpsm_pkg::CPSM_MGMT_ACK: begin
                if (ack_done) begin
                    next_state = cpsm_pkg::CPSM_MGMT_MODE; // [RQ14]
                end
            end
            cpsm_pkg::CPSM_MGMT_MODE: begin
                if (mgmt_handler_done) begin
                    next_state = cpsm_pkg::CPSM_RUN;
                end
            end
            default: begin
                next_state = cpsm_pkg::CPSM_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state <= cpsm_pkg::CPSM_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Acknowledge transaction: held for ACK_CYCLES
    logic ack_start;
    logic [1:0] next_ack_kind;
    always_comb begin
        ack_start = 1'b0;
        next_ack_kind = `CPSM_ACK_NONE;
        if (state == cpsm_pkg::CPSM_RUN &&
            next_state == cpsm_pkg::CPSM_STOPGRANT) begin
            ack_start = 1'b1;
            next_ack_kind = `CPSM_ACK_STOPGRANT; // [RQ7]
        end else if (next_state == cpsm_pkg::CPSM_MGMT_ACK &&
                     state == cpsm_pkg::CPSM_MGMT_SAVE) begin
            ack_start = 1'b1;
            next_ack_kind = `CPSM_ACK_MGMT; // [RQ14]
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ack_cnt <= '0;
            ack_valid <= 1'b0;
            ack_kind <= `CPSM_ACK_NONE;
        end else if (ack_start) begin
            ack_cnt <= `CPSM_ACK_WIDTH'(ACK_CYCLES - 1);
            ack_valid <= 1'b1;
            ack_kind <= next_ack_kind;
        end else if (!ack_done) begin
            ack_cnt <= ack_cnt - 1'b1;
        end else begin
            ack_valid <= 1'b0;
            ack_kind <= `CPSM_ACK_NONE;
        end
    end

    // Clock gating and service enables per state
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            unit_clock_enable <= `CPSM_GATE_ALL;
            snoop_accept <= 1'b0;
            interrupt_accept <= 1'b0;
            executing <= 1'b0;
            power_state <= 3'h0;
        end else begin
            power_state <= next_state;
            unique case (next_state)
                cpsm_pkg::CPSM_STOPGRANT: begin
                    unit_clock_enable <= `CPSM_GATE_STOPGRANT; // [RQ8] [RQ5]
                    snoop_accept <= snoop_request; // [RQ9]
                    interrupt_accept <= interrupt_request; // [RQ9]
                    executing <= 1'b0;
                end
                cpsm_pkg::CPSM_SLEEP: begin
                    unit_clock_enable <= `CPSM_GATE_SLEEP; // [RQ2]
                    snoop_accept <= 1'b0; // [RQ3]
                    interrupt_accept <= 1'b0; // [RQ3]
                    executing <= 1'b0;
                end
                cpsm_pkg::CPSM_DEEP_SLEEP: begin
                    unit_clock_enable <= `CPSM_GATE_DEEP;
                    snoop_accept <= 1'b0;
                    interrupt_accept <= 1'b0;
                    executing <= 1'b0;
                end
                default: begin
                    unit_clock_enable <= `CPSM_GATE_ALL; // [RQ10]
                    snoop_accept <= snoop_request;
                    interrupt_accept <= interrupt_request;
                    executing <= (next_state == cpsm_pkg::CPSM_RUN ||
                                  next_state == cpsm_pkg::CPSM_MGMT_MODE);
                end
            endcase
        end
    end

    // Management mode markers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_save <= 1'b0;
            handler_start <= 1'b0;
            system_management_mode <= 1'b0;
        end else begin
            state_save <= (next_state == cpsm_pkg::CPSM_MGMT_SAVE); // [RQ13]
            handler_start <= (state == cpsm_pkg::CPSM_MGMT_ACK &&
                              next_state == cpsm_pkg::CPSM_MGMT_MODE);
            system_management_mode <=
                (next_state == cpsm_pkg::CPSM_MGMT_SAVE ||
                 next_state == cpsm_pkg::CPSM_MGMT_ACK ||
                 next_state == cpsm_pkg::CPSM_MGMT_MODE);
        end
    end
endmodule
`default_nettype wire

// ==== cpsm_chipset.sv ====
// Chipset model driving the power management request pins
`default_nettype none
module cpsm_chipset (
    input wire logic want_stop,
    input wire logic want_sleep,
    input wire logic want_deep,
    input wire logic want_mgmt,
    input wire logic clock_off,
    output logic stop_clock_request_n,
    output logic sleep_request_n,
    output logic deep_sleep_request_n,
    output logic mgmt_interrupt_n,
    output logic bus_clock_present
);
    timeunit 1ns;
    timeprecision 1ns;
    assign stop_clock_request_n = !want_stop;
    // Sleep only under stop-clock, deep only under sleep
    assign sleep_request_n = !(want_sleep && want_stop);
    assign deep_sleep_request_n = !(want_deep && !sleep_request_n);
    assign mgmt_interrupt_n = !want_mgmt;
    assign bus_clock_present = !clock_off;
endmodule
`default_nettype wire

// ==== cpsm_ctrl_assertions.sv ====
// Port checker for the power state and management interrupt control
`default_nettype none
module cpsm_ctrl_assertions (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic stop_clock_request_n,
    input wire logic sleep_request_n,
    input wire logic mgmt_interrupt_n,
    input wire logic snoop_request,
    input wire logic [3:0] unit_clock_enable,
    input wire logic ack_valid,
    input wire logic [1:0] ack_kind,
    input wire logic snoop_accept,
    input wire logic interrupt_accept,
    input wire logic state_save,
    input wire logic executing,
    input wire logic system_management_mode,
    input wire logic outputs_tristate,
    input wire logic [2:0] power_state
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    property p_sg_gate;
        power_state == 3'h1 |-> unit_clock_enable == 4'hb;
    endproperty
    a_sg_gate: assert property (p_sg_gate)
        else $error("gates in stop");
    property p_sl_gate;
        power_state == 3'h2 |-> unit_clock_enable == 4'h8;
    endproperty
    a_sl_gate: assert property (p_sl_gate)
        else $error("gates in sleep");
    property p_sl_deaf;
        power_state == 3'h2 |-> !snoop_accept && !interrupt_accept;
    endproperty
    a_sl_deaf: assert property (p_sl_deaf)
        else $error("sleep answered");
    property p_sg_ack;
        power_state == 3'h1 && $past(power_state) == 3'h0
            |-> ack_valid && ack_kind == 2'h1;
    endproperty
    a_sg_ack: assert property (p_sg_ack)
        else $error("no stop ack");
    property p_ack_len;
        $rose(ack_valid) |-> ack_valid [*4] ##1 !ack_valid;
    endproperty
    a_ack_len: assert property (p_ack_len)
        else $error("ack length");
    property p_sg_snoop;
        snoop_request && power_state == 3'h1 ##1 power_state == 3'h1
            |-> snoop_accept;
    endproperty
    a_sg_snoop: assert property (p_sg_snoop)
        else $error("snoop lost");
    property p_sl_hold;
        (power_state == 3'h2 && !sleep_request_n) [*3] |=> power_state != 3'h1;
    endproperty
    a_sl_hold: assert property (p_sl_hold)
        else $error("left sleep");
    property p_save;
        power_state == 3'h4 |-> state_save && system_management_mode
            ##1 power_state == 3'h5 && ack_valid && ack_kind == 2'h2;
    endproperty
    a_save: assert property (p_save)
        else $error("mgmt entry");
    property p_sync;
        $fell(stop_clock_request_n) && power_state == 3'h0 && mgmt_interrupt_n
            |=> power_state == 3'h0;
    endproperty
    a_sync: assert property (p_sync)
        else $error("unsynced stop");
    property p_resume;
        $rose(stop_clock_request_n) && power_state == 3'h1 && sleep_request_n
            |-> ##[1:4] power_state == 3'h0 && unit_clock_enable == 4'hf
            && executing;
    endproperty
    a_resume: assert property (p_resume)
        else $error("no resume");
    property p_tri;
        outputs_tristate |=> outputs_tristate;
    endproperty
    a_tri: assert property (p_tri)
        else $error("tristate dropped");
endmodule
bind cpsm_ctrl cpsm_ctrl_assertions i_cpsm_ctrl_assertions (
    .sys_clk(sys_clk), .rstn(rstn),
    .stop_clock_request_n(stop_clock_request_n),
    .sleep_request_n(sleep_request_n), .mgmt_interrupt_n(mgmt_interrupt_n),
    .snoop_request(snoop_request), .unit_clock_enable(unit_clock_enable),
    .ack_valid(ack_valid), .ack_kind(ack_kind), .snoop_accept(snoop_accept),
    .interrupt_accept(interrupt_accept), .state_save(state_save),
    .executing(executing), .system_management_mode(system_management_mode),
    .outputs_tristate(outputs_tristate), .power_state(power_state));
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the power state and management interrupt control
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic want_stop = 1'b0, want_sleep = 1'b0, want_deep = 1'b0;
    logic want_mgmt = 1'b0, clock_off = 1'b0, done = 1'b0;
    logic snoop = 1'b0, irq = 1'b0;
    wire logic stop_n, sleep_n, deep_n, mgmt_n, bclk_ok, ack_valid;
    wire logic snoop_acc, irq_acc, save, start, executing, mode, tri_out;
    wire logic [3:0] gate;
    wire logic [1:0] ack_kind;
    wire logic [2:0] power_state;
    int mismatches = 0;
    int checks_done = 0;
    cpsm_chipset i_cpsm_chipset (.want_stop(want_stop),
        .want_sleep(want_sleep), .want_deep(want_deep), .want_mgmt(want_mgmt),
        .clock_off(clock_off), .stop_clock_request_n(stop_n),
        .sleep_request_n(sleep_n), .deep_sleep_request_n(deep_n),
        .mgmt_interrupt_n(mgmt_n), .bus_clock_present(bclk_ok));
    cpsm_ctrl #(.BCLK_LOSS_CYCLES(4)) i_cpsm_ctrl (.sys_clk(sys_clk),
        .rstn(rstn), .stop_clock_request_n(stop_n), .sleep_request_n(sleep_n),
        .deep_sleep_request_n(deep_n), .mgmt_interrupt_n(mgmt_n),
        .bus_clock_present(bclk_ok), .snoop_request(snoop),
        .interrupt_request(irq), .mgmt_handler_done(done),
        .unit_clock_enable(gate), .ack_valid(ack_valid), .ack_kind(ack_kind),
        .snoop_accept(snoop_acc), .interrupt_accept(irq_acc),
        .state_save(save), .handler_start(start), .executing(executing),
        .system_management_mode(mode), .outputs_tristate(tri_out),
        .power_state(power_state));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h not %h", $time, seen, exp);
        end
    endtask
    task automatic wait_state(input logic [2:0] s);
        int n;
        n = 0;
        while (power_state !== s && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        chk(power_state, s);
    endtask
    task automatic t_stop_grant();
        int n;
        n = 0;
        want_stop = 1'b1;
        @(negedge sys_clk);
        chk(power_state, 3'h0);
        wait_state(3'h1);
        chk(ack_kind, 2'h1);
        chk(gate, 4'hb);
        while (ack_valid === 1'b1 && n < 10) begin
            @(negedge sys_clk);
            n++;
        end
        chk(8'(n), 8'h04);
        snoop = 1'b1;
        irq = 1'b1;
        @(negedge sys_clk);
        chk({snoop_acc, irq_acc}, 2'h3);
        chk(tri_out, 1'b0);
        $display("test stop_grant done");
    endtask
    task automatic t_sleep();
        want_sleep = 1'b1;
        wait_state(3'h2);
        chk(gate, 4'h8);
        repeat (3) @(negedge sys_clk);
        chk({snoop_acc, irq_acc}, 2'h0);
        chk(power_state, 3'h2);
        want_deep = 1'b1;
        wait_state(3'h3);
        chk(gate, 4'h0);
        want_deep = 1'b0;
        wait_state(3'h2);
        clock_off = 1'b1;
        wait_state(3'h3);
        clock_off = 1'b0;
        wait_state(3'h2);
        want_sleep = 1'b0;
        wait_state(3'h1);
        chk(gate, 4'hb);
        snoop = 1'b0;
        irq = 1'b0;
        want_stop = 1'b0;
        wait_state(3'h0);
        chk({gate, executing}, 5'h1f);
        $display("test sleep done");
    endtask
    task automatic t_mgmt();
        want_mgmt = 1'b1;
        repeat (2) @(negedge sys_clk);
        want_mgmt = 1'b0;
        wait_state(3'h4);
        chk({save, mode}, 2'h3);
        wait_state(3'h5);
        chk({ack_valid, ack_kind}, 3'h6);
        wait_state(3'h6);
        chk(start, 1'b1);
        done = 1'b1;
        @(negedge sys_clk);
        done = 1'b0;
        chk(start, 1'b0);
        wait_state(3'h0);
        $display("test mgmt done");
    endtask
    task automatic t_tristate();
        rstn = 1'b0;
        want_mgmt = 1'b1;
        repeat (2) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (3) @(negedge sys_clk);
        chk(tri_out, 1'b1);
        rstn = 1'b0;
        want_mgmt = 1'b0;
        @(negedge sys_clk);
        chk(tri_out, 1'b0);
        rstn = 1'b1;
        $display("test tristate done");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        mismatches++;
        end_of_test();
    end
    initial begin
        repeat (16) @(negedge sys_clk);
        chk({gate, power_state}, 7'h78);
        rstn = 1'b1;
        t_stop_grant();
        t_sleep();
        t_mgmt();
        t_tristate();
        end_of_test();
    end
endmodule
`default_nettype wire
